// *** hpmc_pkg.sv ***
// Summary of operation
// - config byte bit 3 picks standard numbering or re-map mode.
// - standard mode numbers enabled ports in physical order, closing gaps.
// - re-map mode takes numbers and disables from the re-map table input.
// - config byte bit 0 enables string support; bits 7:4 and 2:1 reserved.
// - fixed-port map bits 3..1 flag ports 3..1; bits 7:4 and 0 reserved.
// - self-powered in standard mode, a set off bit 3..1 disables that port.
// - any off combination gives the right count and a packed reordering.
// - the self-powered port disable register resets to zero.
// - bus-powered in standard mode a second off mask does the same, reset 0.
package hpmc_pkg;
    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;
    localparam int NUM_PORTS = 3;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_HCFG = 6'h08;
    localparam logic [5:0] IDX_FIXMAP = 6'h09;
    localparam logic [5:0] IDX_SPOFF = 6'h0A;
    localparam logic [5:0] IDX_BPOFF = 6'h0B;
    localparam logic [5:0] IDX_STAT = 6'h10;
    // field positions
    localparam int HCFG_REMAP_BIT = 3;
    localparam int HCFG_STRING_BIT = 0;
    localparam int PORT_LSB = 1;
    localparam int PORT_MSB = 3;
    localparam int STAT_NUM_LSB = 0;
    localparam int STAT_EN_LSB = 8;
    localparam int STAT_CNT_LSB = 12;
    localparam int STAT_FIX_LSB = 16;
    localparam int STAT_SP_BIT = 20;
    localparam int STAT_MODE_BIT = 21;
    // writable bits; everything else is reserved
    localparam logic [7:0] HCFG_MASK = 8'h09;
    localparam logic [7:0] PORT_MASK = 8'h0E;
    // reset values
    localparam logic [7:0] HCFG_RST = 8'h00;
    localparam logic [7:0] FIXMAP_RST = 8'h00;
    localparam logic [7:0] SPOFF_RST = 8'h00;
    localparam logic [7:0] BPOFF_RST = 8'h00;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // number of set bits in a three-port mask
    function automatic logic [1:0] hpmc_cnt3(input logic [2:0] v);
        return 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
    endfunction
endpackage

// *** hpmc_top.sv ***
`timescale 1ns/1ps
module hpmc_top (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [hpmc_pkg::AXI_ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [hpmc_pkg::AXI_DATA_W-1:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [hpmc_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [hpmc_pkg::AXI_DATA_W-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic SELF_POWERED,
    input wire logic [2*hpmc_pkg::NUM_PORTS-1:0] REMAP_PORT_NUM,
    output logic RENUMBER_MODE,
    output logic STRING_SUPPORT_EN,
    output logic [hpmc_pkg::NUM_PORTS-1:0] PORT_ENABLED,
    output logic [2*hpmc_pkg::NUM_PORTS-1:0] PORT_REPORTED_NUM,
    output logic [1:0] PORT_COUNT,
    output logic [hpmc_pkg::NUM_PORTS-1:0] FIXED_DEVICE_LOGICAL
);
    import hpmc_pkg::*;

    logic [7:0] hcfg_r;
    logic [7:0] fixmap_r;
    logic [7:0] spoff_r;
    logic [7:0] bpoff_r;
    logic aw_held_r;
    logic w_held_r;
    logic [AXI_ADDR_W-1:0] aw_addr_r;
    logic [7:0] w_data_r;
    logic w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [AXI_DATA_W-1:0] rdata_r;
    logic sp_meta_r;
    logic sp_sync_r;
    logic mode_r;
    logic string_r;
    logic [2:0] en_r;
    logic [5:0] num_r;
    logic [1:0] cnt_r;
    logic [2:0] fix_r;

    // write channel: address and data are caught separately, in any order
    wire aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
    wire w_take = S_AXI_WVALID & S_AXI_WREADY;
    wire wr_fire = aw_held_r & w_held_r & ~bvalid_r;
    wire [5:0] wr_idx = aw_addr_r[AXI_ADDR_W-1:2];
    wire wr_align = (aw_addr_r[1:0] == 2'h0);
    wire sel_hcfg = wr_align & (wr_idx == IDX_HCFG);
    wire sel_fixmap = wr_align & (wr_idx == IDX_FIXMAP);
    wire sel_spoff = wr_align & (wr_idx == IDX_SPOFF);
    wire sel_bpoff = wr_align & (wr_idx == IDX_BPOFF);
    wire sel_stat = wr_align & (wr_idx == IDX_STAT);
    wire wr_hit = sel_hcfg | sel_fixmap | sel_spoff | sel_bpoff | sel_stat;
    wire wr_en = wr_fire & w_strb_r;

    // no new beat while a response is still waiting for bready
    assign S_AXI_AWREADY = ~aw_held_r & ~bvalid_r;
    assign S_AXI_WREADY = ~w_held_r & ~bvalid_r;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (aw_take) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= S_AXI_AWADDR;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end
    end

    // only byte lane 0 carries register bits
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            w_held_r <= 1'b0;
            w_data_r <= 8'h00;
            w_strb_r <= 1'b0;
        end else if (w_take) begin
            w_held_r <= 1'b1;
            w_data_r <= S_AXI_WDATA[7:0];
            w_strb_r <= S_AXI_WSTRB[0];
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end
    end

    // response one cycle after both halves are held
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_r <= 1'b0;
        end
    end

    // configuration registers; reserved bits masked off on the way in
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            hcfg_r <= HCFG_RST;
            fixmap_r <= FIXMAP_RST;
            spoff_r <= SPOFF_RST;
            bpoff_r <= BPOFF_RST;
        end else if (wr_en) begin
            if (sel_hcfg) hcfg_r <= w_data_r & HCFG_MASK;
            if (sel_fixmap) fixmap_r <= w_data_r & PORT_MASK;
            if (sel_spoff) spoff_r <= w_data_r & PORT_MASK;
            if (sel_bpoff) bpoff_r <= w_data_r & PORT_MASK;
        end
    end

    // power mode strap arrives from a pin
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sp_meta_r <= 1'b0;
            sp_sync_r <= 1'b0;
        end else begin
            sp_meta_r <= SELF_POWERED;
            sp_sync_r <= sp_meta_r;
        end
    end

    // port selection: off-mask depends on how the hub is powered
    wire remap_on = hcfg_r[HCFG_REMAP_BIT];
    wire [2:0] sp_off = spoff_r[PORT_MSB:PORT_LSB];
    wire [2:0] bp_off = bpoff_r[PORT_MSB:PORT_LSB];
    wire [2:0] off_mask = sp_sync_r ? sp_off : bp_off;
    wire [2:0] std_en = ~off_mask;
    wire [2:0] fix_phys = fixmap_r[PORT_MSB:PORT_LSB];
    wire [1:0] num_sel [NUM_PORTS];
    wire [2:0] en_sel;
    wire [2:0] fix_log;
    wire [5:0] num_flat;

    // per physical port: packed number in standard mode, table in re-map
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        localparam logic [2:0] LOW = 3'((4'h1 << (p + 1)) - 4'h1);
        wire [1:0] std_num = std_en[p] ? hpmc_cnt3(std_en & LOW) : 2'h0;
        wire [1:0] rm_num = REMAP_PORT_NUM[2*p+1:2*p];
        assign num_sel[p] = remap_on ? rm_num : std_num;
        assign en_sel[p] = (num_sel[p] != 2'h0);
        assign num_flat[2*p+1:2*p] = num_sel[p];
    end

    // per reported port: gather the fixed flag of the port mapped onto it
    for (genvar l = 0; l < NUM_PORTS; l++) begin : g_log
        wire [2:0] hit;
        for (genvar q = 0; q < NUM_PORTS; q++) begin : g_match
            assign hit[q] = (num_sel[q] == 2'(l + 1));
        end
        assign fix_log[l] = |(hit & fix_phys);
    end

    // outputs held in flops so the host side sees clean levels
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_r <= 1'b0;
            string_r <= 1'b0;
            en_r <= 3'h0;
            num_r <= 6'h00;
            cnt_r <= 2'h0;
            fix_r <= 3'h0;
        end else begin
            mode_r <= remap_on;
            string_r <= hcfg_r[HCFG_STRING_BIT];
            en_r <= en_sel;
            num_r <= num_flat;
            cnt_r <= hpmc_cnt3(en_sel);
            fix_r <= fix_log;
        end
    end

    assign RENUMBER_MODE = mode_r;
    assign STRING_SUPPORT_EN = string_r;
    assign PORT_ENABLED = en_r;
    assign PORT_REPORTED_NUM = num_r;
    assign PORT_COUNT = cnt_r;
    assign FIXED_DEVICE_LOGICAL = fix_r;

    // read channel: one outstanding read, answered the next cycle
    wire ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
    wire [5:0] rd_idx = S_AXI_ARADDR[AXI_ADDR_W-1:2];
    wire rd_align = (S_AXI_ARADDR[1:0] == 2'h0);
    // widen each field before shifting so no bit falls off the top
    wire [AXI_DATA_W-1:0] stat_word =
        (32'(sp_sync_r) << STAT_SP_BIT) |
        (32'(mode_r) << STAT_MODE_BIT) |
        (32'(fix_r) << STAT_FIX_LSB) |
        (32'(cnt_r) << STAT_CNT_LSB) |
        (32'(en_r) << STAT_EN_LSB) |
        (32'(num_r) << STAT_NUM_LSB);
    wire rd_hcfg = rd_align & (rd_idx == IDX_HCFG);
    wire rd_fixmap = rd_align & (rd_idx == IDX_FIXMAP);
    wire rd_spoff = rd_align & (rd_idx == IDX_SPOFF);
    wire rd_bpoff = rd_align & (rd_idx == IDX_BPOFF);
    wire rd_stat = rd_align & (rd_idx == IDX_STAT);
    wire rd_hit = rd_hcfg | rd_fixmap | rd_spoff | rd_bpoff | rd_stat;
    wire [AXI_DATA_W-1:0] rd_word =
        rd_hcfg ? {24'h000000, hcfg_r} :
        rd_fixmap ? {24'h000000, fixmap_r} :
        rd_spoff ? {24'h000000, spoff_r} :
        rd_bpoff ? {24'h000000, bpoff_r} :
        rd_stat ? stat_word : 32'h00000000;

    assign S_AXI_ARREADY = ~rvalid_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RDATA = rdata_r;
    assign S_AXI_RRESP = rresp_r;

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h00000000;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_r <= rd_word;
        end else if (S_AXI_RREADY) begin
            rvalid_r <= 1'b0;
        end
    end

    // checks
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);

    sequence s_hcfg_wr;
        wr_en && sel_hcfg;
    endsequence

    AST_REMAP_SELECT: assert property (
        s_hcfg_wr ##0 w_data_r[HCFG_REMAP_BIT] |-> ##2 RENUMBER_MODE)
        else $error("re-map select did not reach the mode output");
    AST_STD_CONTIG: assert property (
        !RENUMBER_MODE && PORT_ENABLED[2] |->
        PORT_REPORTED_NUM[5:4] == PORT_COUNT)
        else $error("highest enabled port not numbered last");
    AST_REMAP_SRC: assert property (
        remap_on |=> PORT_REPORTED_NUM == $past(REMAP_PORT_NUM))
        else $error("re-map numbers not taken from the table");
    AST_STRING: assert property (
        s_hcfg_wr ##0 !w_data_r[HCFG_STRING_BIT] |-> ##2 !STRING_SUPPORT_EN)
        else $error("string support not cleared by write");
    AST_FIXED_MAP: assert property (
        !remap_on && off_mask == 3'h0 |=>
        FIXED_DEVICE_LOGICAL == $past(fix_phys))
        else $error("fixed port flags misplaced");
    AST_SP_OFF: assert property (
        sp_sync_r && !remap_on |=> (PORT_ENABLED & $past(sp_off)) == 3'h0)
        else $error("self-powered disabled port is enabled");
    AST_COUNT: assert property (
        PORT_COUNT == 2'($countones(PORT_ENABLED)))
        else $error("enabled count does not match enables");
    AST_PDS_RESET: assert property (
        $rose(RST_N) |-> spoff_r == SPOFF_RST)
        else $error("self-powered disable not zero after reset");
    AST_BP_OFF: assert property (
        !sp_sync_r && !remap_on |=> (PORT_ENABLED & $past(bp_off)) == 3'h0)
        else $error("bus-powered disabled port is enabled");
    AST_RESERVED: assert property (
        wr_en && sel_fixmap |=> (fixmap_r & ~PORT_MASK) == 8'h00)
        else $error("reserved bit stored");
endmodule // hpmc_top

// *** hpmc_host_model.sv ***
`timescale 1ns/1ps
module hpmc_host_model (
    input wire logic clk,
    input wire logic sp_set,
    input wire logic [5:0] rm_set,
    input wire logic [2:0] port_en,
    output logic self_powered,
    output logic [5:0] remap_num,
    output logic [1:0] seen_cnt
);
    import hpmc_pkg::*;
    // power strap and external re-map table move only after an edge
    always_ff @(posedge clk) begin
        self_powered <= sp_set;
        remap_num <= rm_set;
    end
    // host counts only ports it can enumerate
    assign seen_cnt = 2'(port_en[0]) + 2'(port_en[1]) + 2'(port_en[2]);
    // a fixed device answers with its own descriptors, none from the hub
endmodule // hpmc_host_model

// *** tb_top.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
error_cnt++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top;
    import hpmc_pkg::*;
    logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, sp, sp_set, mode, str;
    logic [7:0] awaddr, araddr, adr [4], msk [4];
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, cnt, seen;
    logic [5:0] rm, rm_set, nums;
    logic [2:0] en, fix;
    int error_cnt, total_checks;
    hpmc_top i_hpmc_top (.CORE_CLK(clk), .RST_N(rst_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .SELF_POWERED(sp),
        .REMAP_PORT_NUM(rm), .RENUMBER_MODE(mode), .STRING_SUPPORT_EN(str),
        .PORT_ENABLED(en), .PORT_REPORTED_NUM(nums), .PORT_COUNT(cnt),
        .FIXED_DEVICE_LOGICAL(fix));
    hpmc_host_model i_hpmc_host_model (.clk(clk), .sp_set(sp_set),
        .rm_set(rm_set), .port_en(en), .self_powered(sp),
        .remap_num(rm), .seen_cnt(seen));
    // clock at 50 ns
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n > 50) begin
            error_cnt++;
            stop_test();
        end
    endtask
    // readies sampled at the falling edge so they match the next rising edge
    task automatic wr(input logic [7:0] a, d, output logic [1:0] r);
        int n;
        logic pa, pw, ta, tw;
        n = 0; pa = 1'b1; pw = 1'b1;
        awaddr <= a; wdata <= {24'h0, d}; wstrb <= 4'hF;
        awvalid <= 1'b1; wvalid <= 1'b1;
        while (pa || pw) begin
            @(negedge clk); ta = pa && awready; tw = pw && wready;
            @(posedge clk); n++; tmo(n);
            if (ta) begin pa = 1'b0; awvalid <= 1'b0; end
            if (tw) begin pw = 1'b0; wvalid <= 1'b0; end
        end
        bready <= 1'b1; ta = 1'b0; n = 0;
        while (!ta) begin
            @(negedge clk); ta = bvalid; r = bresp;
            @(posedge clk); n++; tmo(n);
        end
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        logic t;
        n = 0; t = 1'b0; araddr <= a; arvalid <= 1'b1;
        while (!t) begin
            @(negedge clk); t = arready;
            @(posedge clk); n++; tmo(n);
        end
        arvalid <= 1'b0; rready <= 1'b1; t = 1'b0; n = 0;
        while (!t) begin
            @(negedge clk); t = rvalid; d = rdata; r = rresp;
            @(posedge clk); n++; tmo(n);
        end
        rready <= 1'b0;
    endtask
    // host view: {fixed, count, enables, numbers}
    function automatic logic [13:0] exp_hub(logic [7:0] c3, nr, ps, pb,
                                            logic s, logic [5:0] rmp);
        logic [2:0] e, fx;
        logic [5:0] nm;
        logic [1:0] k;
        e = 3'h0; fx = 3'h0; nm = 6'h00; k = 2'h0;
        for (int p = 0; p < 3; p++) begin
            if (c3[3]) nm[2*p+:2] = rmp[2*p+:2];
            else if (!(s ? ps[p+1] : pb[p+1])) begin
                k++; nm[2*p+:2] = k;
            end
            e[p] = nm[2*p+:2] != 2'h0;
            if (e[p] && nr[p+1]) fx[nm[2*p+:2]-1] = 1'b1;
        end
        return {fx, 2'(e[0]) + 2'(e[1]) + 2'(e[2]), e, nm};
    endfunction
    // derived outputs settle 4 edges after sp_set moves: host model flop, two sync flops, output flop
    task automatic run_cfg(input logic [7:0] c3, nr, ps, pb,
                           input logic s, input logic [5:0] rmp);
        logic [1:0] r;
        logic [13:0] x;
        logic [31:0] d, st;
        wr(adr[0], c3, r); wr(adr[1], nr, r);
        wr(adr[2], ps, r); wr(adr[3], pb, r);
        sp_set <= s; rm_set <= rmp;
        x = exp_hub(c3, nr, ps, pb, s, rmp);
        repeat (4) @(posedge clk);
        @(negedge clk);
        `CHK("ports", x, {fix, cnt, en, nums})
        `CHK("mode", c3[3], mode)
        `CHK("string", c3[0], str)
        `CHK("host count", x[10:9], seen)
        @(posedge clk);
        // status word: mode, power, fixed, count, enables, numbers
        st = (32'(c3[3]) << STAT_MODE_BIT) | (32'(s) << STAT_SP_BIT) |
             (32'(x[13:11]) << STAT_FIX_LSB) |
             (32'(x[10:9]) << STAT_CNT_LSB) |
             (32'(x[8:6]) << STAT_EN_LSB) | (32'(x[5:0]) << STAT_NUM_LSB);
        rd({IDX_STAT, 2'h0}, d, r);
        `CHK("status", st, d)
    endtask
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        error_cnt = 0; total_checks = 0; rst_n = 1'b0;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
        rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
        wstrb = 4'h0; sp_set = 1'b0; rm_set = 6'h00;
        adr = '{{IDX_HCFG, 2'h0}, {IDX_FIXMAP, 2'h0}, {IDX_SPOFF, 2'h0},
                {IDX_BPOFF, 2'h0}};
        msk = '{HCFG_MASK, PORT_MASK, PORT_MASK, PORT_MASK};
        void'($urandom(32'h5CFA9F42));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            rd(adr[i], d, r);
            `CHK("reset value", 32'h0, d)
        end
        run_cfg(8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 6'h00);
        $display("test reset done");
        // reserved bits drop out, writable bits stick
        for (int i = 0; i < 4; i++) begin
            wr(adr[i], 8'hFF, r);
            rd(adr[i], d, r);
            `CHK("masked readback", {24'h0, msk[i]}, d)
        end
        $display("test reserved done");
        wr(8'h30, 8'h01, r);
        `CHK("unmapped write", RESP_SLVERR, r)
        rd(8'h30, d, r);
        `CHK("unmapped read", {RESP_SLVERR, 32'h0}, {r, d})
        wr(8'h21, 8'h00, r);
        `CHK("unaligned write", RESP_SLVERR, r)
        rd(adr[0], d, r);
        `CHK("unaligned kept", {24'h0, HCFG_MASK}, d)
        $display("test unmapped done");
        // a reset in mid-run must clear registers that hold written bits
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            rd(adr[i], d, r);
            `CHK("mid-run reset", 32'h0, d)
        end
        $display("test mid reset done");
        // corners: every port off, middle off, re-map with a hole
        run_cfg(8'h01, 8'h0E, 8'h0E, 8'h00, 1'b1, 6'h00);
        run_cfg(8'hF0, 8'h08, 8'h0E, 8'h04, 1'b0, 6'h00);
        run_cfg(8'h08, 8'h06, 8'h0E, 8'h0E, 1'b1, 6'h21);
        for (int i = 0; i < 30; i++) begin
            run_cfg(8'($urandom), 8'($urandom), 8'($urandom),
                    8'($urandom), 1'($urandom), 6'($urandom));
        end
        $display("test mapping done");
        stop_test();
    end
endmodule // tb_top
